/* File: core/radio_status_consts.svh */
// Offsets, field positions, reset values and codes of the radio status block.
// Assumes inclusion by bare name from the package, the checker and the bench.
`ifndef RADIO_STATUS_CONSTS_SVH
`define RADIO_STATUS_CONSTS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define RS_IDX_SIGNAL_STRENGTH  16'hdf3a
`define RS_IDX_RADIO_FSM_STATE  16'hdf3b
`define RS_IDX_PACKET_FLAGS     16'hdf3c
`define RS_IDX_SYNTH_TUNE       16'hdf3d
`define RS_IDX_TEST_OUT_CONFIG0 16'hdf40
`define RS_IDX_TEST_OUT_CONFIG1 16'hdf41
`define RS_IDX_TEST_OUT_CONFIG2 16'hdf42
`define RS_IDX_PORT1_FUNC_SEL   16'hdf43
`define RS_IDX_IRQ_STATUS       16'hdf44
`define RS_IDX_IRQ_MASK         16'hdf45

// ==========================================================================
// Reset values
`define RS_RST_SIGNAL_STRENGTH  8'h80
`define RS_RST_SYNTH_TUNE       8'h94
`define RS_RST_FSM_CODE         5'h01

// ==========================================================================
// Packet flag bit positions
`define RS_BIT_CRC_MATCH        7
`define RS_BIT_CARRIER_SENSE    6
`define RS_BIT_PREAMBLE_MET     5
`define RS_BIT_CHANNEL_CLEAR    4
`define RS_BIT_FRAME_SYNC       3

// ==========================================================================
// Interrupt status bit positions
`define RS_IRQ_CRC_MATCH        0
`define RS_IRQ_FRAME_SYNC       1
`define RS_IRQ_RX_OVERRUN       2
`define RS_IRQ_TX_UNDERRUN      3
`define RS_IRQ_BITS             4

`endif

/* File: core/radio_status_pkg.sv */
// Types shared by the radio status block and its helper modules.
// Assumes radio_status_consts.svh is on the include path.
`include "radio_status_consts.svh"

package radio_status_pkg;

  // ========================================================================
  // Radio control state codes
  typedef enum logic [4:0] {
    FSM_SLEEP = 5'h00, FSM_IDLE = 5'h01, FSM_UNUSED = 5'h02,
    FSM_MC_VCO_ON = 5'h03, FSM_MC_REG_ON = 5'h04, FSM_MC_CAL = 5'h05,
    FSM_WAKE_VCO_ON = 5'h06, FSM_WAKE_REG_ON = 5'h07, FSM_CAL_START = 5'h08,
    FSM_SETTLE_BOOST = 5'h09, FSM_SETTLE_LOCK = 5'h0a, FSM_SETTLE_ADC = 5'h0b,
    FSM_CAL_END = 5'h0c, FSM_RX = 5'h0d, FSM_RX_END = 5'h0e, FSM_RX_RESTART = 5'h0f,
    FSM_RX_TO_TX = 5'h10, FSM_RX_OVERRUN = 5'h11, FSM_SYNTH_ON = 5'h12,
    FSM_TX = 5'h13, FSM_TX_END = 5'h14, FSM_TX_TO_RX = 5'h15, FSM_TX_UNDERRUN = 5'h16
  } radio_fsm_code_t;

  // ========================================================================
  // Test output selector codes
  typedef enum logic [5:0] {
    SEL_NORMAL      = 6'h00,
    SEL_PREAMBLE    = 6'h08,
    SEL_CHAN_CLEAR  = 6'h09,
    SEL_CARRIER     = 6'h0e,
    SEL_CRC_MATCH   = 6'h0f,
    SEL_AMP_EN_N    = 6'h1b,
    SEL_LNA_EN_N    = 6'h1c,
    SEL_TIE_LOW     = 6'h2f
  } test_sel_t;

endpackage : radio_status_pkg

/* File: core/radio_status_if.sv */
// Status bits and pin selectors passed between the status block's modules.
// Assumes one producer of status and one test output multiplexer.
interface radio_status_if;
  import radio_status_pkg::*;

  logic            crc_match;
  logic            carrier_sense;
  logic            preamble_quality_met;
  logic            channel_clear;
  logic            in_tx;
  logic            in_rx;
  logic            frame_sync_active;
  logic [2:0][5:0] test_out_select;
  logic [2:0]      test_out;
  logic [2:0]      test_active;

  modport core (output crc_match, carrier_sense, preamble_quality_met, channel_clear,
                output in_tx, in_rx, test_out_select, input frame_sync_active,
                input test_out, test_active);
  modport sync (output frame_sync_active);
  modport mux  (input crc_match, carrier_sense, preamble_quality_met, channel_clear,
                input in_tx, in_rx, test_out_select, output test_out, test_active);
endinterface : radio_status_if

/* File: core/test_out_mux.sv */
// Picks one internal status signal for each of three port pins.
// Assumes registered status bits; the caller registers the pin result.
module test_out_mux
  import radio_status_pkg::*;
(
  // Status and selectors
  radio_status_if.mux st
);

  // ========================================================================
  // One selector per pin
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      always_comb begin
        st.test_active[g] = (st.test_out_select[g] != SEL_NORMAL);
        unique case (st.test_out_select[g])
          SEL_PREAMBLE:   st.test_out[g] = st.preamble_quality_met;
          SEL_CHAN_CLEAR: st.test_out[g] = st.channel_clear;
          SEL_CARRIER:    st.test_out[g] = st.carrier_sense;
          SEL_CRC_MATCH:  st.test_out[g] = st.crc_match;
          SEL_AMP_EN_N:   st.test_out[g] = ~st.in_tx;
          SEL_LNA_EN_N:   st.test_out[g] = ~st.in_rx;
          default:        st.test_out[g] = 1'b0;  // Reserved codes drive low
        endcase
      end
    end
  endgenerate

endmodule : test_out_mux

/* File: core/frame_sync_tracker.sv */
// Tracks the frame sync flag across sync word, packet end and error states.
// Assumes the radio control code is already registered in the pclk domain.
module frame_sync_tracker
  import radio_status_pkg::*;
(
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // Radio events
  input  wire logic            sync_word_seen,
  input  wire logic            packet_end,
  input  wire logic            addr_check_fail,
  input  wire radio_fsm_code_t fsm_code,
  input  wire logic            in_rx,
  // Flag out
  radio_status_if.sync         st
);

  // ========================================================================
  // Flag: any lowering cause wins over a raise in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.frame_sync_active <= 1'b0;
    end else if (packet_end) begin
      st.frame_sync_active <= 1'b0;
    end else if ((in_rx && addr_check_fail) || fsm_code == FSM_RX_OVERRUN) begin
      st.frame_sync_active <= 1'b0;
    end else if (fsm_code == FSM_TX_UNDERRUN) begin
      st.frame_sync_active <= 1'b0;
    end else if (sync_word_seen) begin
      st.frame_sync_active <= 1'b1;
    end
  end

endmodule : frame_sync_tracker

/* File: core/radio_status_and_test_out.sv */
// Radio status registers, test output pin routing and regulator control.
// Assumes radio datapath signals are synchronous to pclk and an APB master.
//
// Notes on behaviour
// - Signal strength register, read-only, resets 0x80
// - Five-bit state code, upper bits zero, idle reset
// - Calibration, wakeup and settling state codes
// - Receive, transmit, switching and error state codes
// - CRC match set on match, cleared entering receive
// - Carrier, preamble, clear channel flags; low bits zero
// - Frame sync up on sync word, down at end
// - Receive: address fail or overrun drops frame sync
// - Transmit: underrun drops frame sync
// - Synthesizer tune readback, read-only, resets 0x94
// - Each of three pins has six-bit selector
// - Nonzero selector overrides function select, forces output
// - Regulator off in deep power modes, state kept
// - Selector codes for normal and status signals
// - Active-low amplifier enables in transmit and receive
//
// Design decision made here: register access over APB.
module radio_status_and_test_out
  import radio_status_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Radio datapath status
  input  wire logic [7:0]  signal_strength_in,
  input  wire logic [4:0]  radio_fsm_code_in,
  input  wire logic        crc_result_valid,
  input  wire logic        crc_result_match,
  input  wire logic        carrier_sense_in,
  input  wire logic        preamble_quality_met_in,
  input  wire logic        channel_clear_in,
  input  wire logic        sync_word_seen,
  input  wire logic        packet_end,
  input  wire logic        addr_check_fail,
  input  wire logic [7:0]  synth_tune_in,
  // Normal port functions for pins 5..7 of port 1
  input  wire logic [2:0]  gpio_out,
  input  wire logic [2:0]  gpio_oe_n,
  input  wire logic [2:0]  periph_out,
  input  wire logic [2:0]  periph_oe_n,
  // Port pins 5..7 of port 1
  output logic [2:0]       pin_out,
  output logic [2:0]       pin_oe_n,
  // Power control
  input  wire logic [1:0]  power_mode,
  output logic             core_regulator_en,
  // Interrupt
  output logic             irq
);

  // ==========================================================================
  // Internal state
  radio_status_if st ();

  logic [7:0]            signal_strength_q;
  radio_fsm_code_t       fsm_code_q;
  radio_fsm_code_t       fsm_code_prev_q;
  logic                  crc_match_q;
  logic                  carrier_sense_q;
  logic                  preamble_met_q;
  logic                  channel_clear_q;
  logic [7:0]            synth_tune_q;
  logic [2:0][5:0]       test_out_select_q;
  logic [2:0]            port1_function_select_q;
  logic [`RS_IRQ_BITS-1:0] irq_status_q;
  logic [`RS_IRQ_BITS-1:0] irq_mask_q;
  logic                  frame_sync_prev_q;
  logic                  crc_match_prev_q;
  logic [31:0]           prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;
  logic [2:0]            pin_out_q;
  logic [2:0]            pin_oe_n_q;
  logic                  core_regulator_en_q;
  logic                  irq_q;

  logic                  in_rx;
  logic                  in_tx;
  logic                  rx_entry;
  logic [`RS_IRQ_BITS-1:0] irq_events;
  logic                  access_done;
  logic                  wr_done;
  logic [15:0]           reg_index;
  logic                  addr_ok;
  logic                  mapped;
  logic [7:0]            rd_byte;

  // ==========================================================================
  // Radio status sampling
  // Every status field is captured on the same edge, so one read is coherent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      signal_strength_q <= `RS_RST_SIGNAL_STRENGTH;
      synth_tune_q      <= `RS_RST_SYNTH_TUNE;
    end else begin
      signal_strength_q <= signal_strength_in;
      synth_tune_q      <= synth_tune_in;
    end
  end

  // Radio control code, with last value kept for entry detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsm_code_q      <= FSM_IDLE;
      fsm_code_prev_q <= FSM_IDLE;
    end else begin
      fsm_code_q      <= radio_fsm_code_t'(radio_fsm_code_in);
      fsm_code_prev_q <= fsm_code_q;
    end
  end

  // Receive and transmit groups of state codes
  always_comb begin
    in_rx = (fsm_code_q == FSM_RX) || (fsm_code_q == FSM_RX_END)
         || (fsm_code_q == FSM_RX_RESTART);
    in_tx = (fsm_code_q == FSM_TX) || (fsm_code_q == FSM_TX_END);
  end

  // Entering receive: restart passes through the restart code into receive
  assign rx_entry = (fsm_code_q == FSM_RX) && (fsm_code_prev_q != FSM_RX);

  // ==========================================================================
  // Packet flags
  // Clear on receive entry yields to a match reported on that same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_match_q <= 1'b0;
    end else if (crc_result_valid) begin
      crc_match_q <= crc_result_match;
    end else if (rx_entry) begin
      crc_match_q <= 1'b0;
    end
  end

  // Live flags from the demodulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_sense_q <= 1'b0;
      preamble_met_q  <= 1'b0;
      channel_clear_q <= 1'b0;
    end else begin
      carrier_sense_q <= carrier_sense_in;
      preamble_met_q  <= preamble_quality_met_in;
      channel_clear_q <= channel_clear_in;
    end
  end

  // Frame sync tracking
  frame_sync_tracker u_sync (
    .pclk            (pclk),
    .presetn         (presetn),
    .sync_word_seen  (sync_word_seen),
    .packet_end      (packet_end),
    .addr_check_fail (addr_check_fail),
    .fsm_code        (fsm_code_q),
    .in_rx           (in_rx),
    .st              (st.sync)
  );

  // ==========================================================================
  // Test output selection
  assign st.crc_match            = crc_match_q;
  assign st.carrier_sense        = carrier_sense_q;
  assign st.preamble_quality_met = preamble_met_q;
  assign st.channel_clear        = channel_clear_q;
  assign st.in_tx                = in_tx;
  assign st.in_rx                = in_rx;
  assign st.test_out_select      = test_out_select_q;

  test_out_mux u_mux (
    .st (st.mux)
  );

  // Pin drive; a test selection beats the port's own function choice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q  <= 3'h0;
      pin_oe_n_q <= 3'h7;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (st.test_active[i]) begin
          pin_out_q[i]  <= st.test_out[i];
          pin_oe_n_q[i] <= 1'b0;
        end else if (port1_function_select_q[i]) begin
          pin_out_q[i]  <= periph_out[i];
          pin_oe_n_q[i] <= periph_oe_n[i];
        end else begin
          pin_out_q[i]  <= gpio_out[i];
          pin_oe_n_q[i] <= gpio_oe_n[i];
        end
      end
    end
  end

  // ==========================================================================
  // Regulator control
  // Only presetn clears state; power modes touch only the regulator enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_regulator_en_q <= 1'b1;
    end else begin
      core_regulator_en_q <= (power_mode != 2'h2) && (power_mode != 2'h3);
    end
  end

  // ==========================================================================
  // Interrupt events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_sync_prev_q <= 1'b0;
      crc_match_prev_q  <= 1'b0;
    end else begin
      frame_sync_prev_q <= st.frame_sync_active;
      crc_match_prev_q  <= crc_match_q;
    end
  end

  // Rising edges of flags and entries into error states
  always_comb begin
    irq_events = '0;
    irq_events[`RS_IRQ_CRC_MATCH]  = crc_match_q && !crc_match_prev_q;
    irq_events[`RS_IRQ_FRAME_SYNC] = st.frame_sync_active && !frame_sync_prev_q;
    irq_events[`RS_IRQ_RX_OVERRUN] = (fsm_code_q == FSM_RX_OVERRUN)
                                  && (fsm_code_prev_q != FSM_RX_OVERRUN);
    irq_events[`RS_IRQ_TX_UNDERRUN] = (fsm_code_q == FSM_TX_UNDERRUN)
                                   && (fsm_code_prev_q != FSM_TX_UNDERRUN);
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
    end else if (wr_done && reg_index == `RS_IDX_IRQ_STATUS) begin
      irq_status_q <= (irq_status_q & ~pwdata[`RS_IRQ_BITS-1:0]) | irq_events;
    end else begin
      irq_status_q <= irq_status_q | irq_events;
    end
  end

  // Level interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // ==========================================================================
  // APB decode
  // One wait state: the access cycle after setup always stalls once
  assign reg_index   = paddr[17:2];
  assign addr_ok     = (paddr[31:18] == 14'h0) && (paddr[1:0] == 2'h0);
  assign access_done = psel && penable && pready_q;
  assign wr_done     = access_done && pwrite && pstrb[0] && mapped;

  // Read data mux; unused and upper bits read zero
  always_comb begin
    mapped  = addr_ok;
    rd_byte = 8'h00;
    unique case (reg_index)
      `RS_IDX_SIGNAL_STRENGTH:  rd_byte = signal_strength_q;
      `RS_IDX_RADIO_FSM_STATE:  rd_byte = {3'h0, fsm_code_q};
      `RS_IDX_PACKET_FLAGS: begin
        rd_byte[`RS_BIT_CRC_MATCH]     = crc_match_q;
        rd_byte[`RS_BIT_CARRIER_SENSE] = carrier_sense_q;
        rd_byte[`RS_BIT_PREAMBLE_MET]  = preamble_met_q;
        rd_byte[`RS_BIT_CHANNEL_CLEAR] = channel_clear_q;
        rd_byte[`RS_BIT_FRAME_SYNC]    = st.frame_sync_active;
      end
      `RS_IDX_SYNTH_TUNE:       rd_byte = synth_tune_q;
      `RS_IDX_TEST_OUT_CONFIG0: rd_byte = {2'h0, test_out_select_q[0]};
      `RS_IDX_TEST_OUT_CONFIG1: rd_byte = {2'h0, test_out_select_q[1]};
      `RS_IDX_TEST_OUT_CONFIG2: rd_byte = {2'h0, test_out_select_q[2]};
      `RS_IDX_PORT1_FUNC_SEL:   rd_byte = {5'h0, port1_function_select_q};
      `RS_IDX_IRQ_STATUS:       rd_byte = {4'h0, irq_status_q};
      `RS_IDX_IRQ_MASK:         rd_byte = {4'h0, irq_mask_q};
      default:                  mapped  = 1'b0;
    endcase
  end

  // Handshake and read capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= {24'h0, rd_byte};
      end
    end
  end

  // ==========================================================================
  // Writable configuration; read-only registers have no write path, IRQ status clears above
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_out_select_q       <= '0;
      port1_function_select_q <= 3'h0;
      irq_mask_q              <= '0;
    end else if (wr_done) begin
      unique case (reg_index)
        `RS_IDX_TEST_OUT_CONFIG0: test_out_select_q[0] <= pwdata[5:0];
        `RS_IDX_TEST_OUT_CONFIG1: test_out_select_q[1] <= pwdata[5:0];
        `RS_IDX_TEST_OUT_CONFIG2: test_out_select_q[2] <= pwdata[5:0];
        `RS_IDX_PORT1_FUNC_SEL:   port1_function_select_q <= pwdata[2:0];
        `RS_IDX_IRQ_MASK:         irq_mask_q <= pwdata[`RS_IRQ_BITS-1:0];
        default: ;  // Read-only and status writes fall through untouched
      endcase
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign pin_out           = pin_out_q;
  assign pin_oe_n          = pin_oe_n_q;
  assign core_regulator_en = core_regulator_en_q;
  assign irq               = irq_q;

endmodule : radio_status_and_test_out

/* File: dv/radio_status_sva.sv */
// Port checks: APB answers, pin routing, regulator.
// Assumes one pclk domain; bound to the top module.
`include "radio_status_consts.svh"
module radio_status_sva (
  // Clock and reset
  input logic        pclk,
  input logic        presetn,
  // APB
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0]  pstrb,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // Radio, pins, power
  input logic [4:0]  radio_fsm_code_in,
  input logic [2:0]  pin_out,
  input logic [2:0]  pin_oe_n,
  input logic [1:0]  power_mode,
  input logic        core_regulator_en
);
  logic [5:0] sel0_q;
  logic       done;
  // ======
  // Shadow of the pin 5 selector; refused writes never reach it
  assign done = psel && penable && pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel0_q <= 6'h00;
    end else if (done && pwrite && !pslverr && pstrb[0] && paddr[17:2] == `RS_IDX_TEST_OUT_CONFIG0) begin
      sel0_q <= pwdata[5:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ======
  // Three cycles of hold cover the status and pin registers
  sequence s_amp_tx; (sel0_q == 6'h1b && radio_fsm_code_in == 5'h13) [*3]; endsequence
  sequence s_amp_idle; (sel0_q == 6'h1b && radio_fsm_code_in == 5'h01) [*3]; endsequence
  sequence s_lna_rx; (sel0_q == 6'h1c && radio_fsm_code_in == 5'h0d) [*3]; endsequence
  property p_amp_tx; s_amp_tx |=> !pin_out[0]; endproperty
  property p_amp_idle; s_amp_idle |=> pin_out[0]; endproperty
  property p_lna_rx; s_lna_rx |=> !pin_out[0]; endproperty
  property p_force_out; sel0_q != 6'h00 |=> !pin_oe_n[0]; endproperty
  property p_reg_off; power_mode[1] |=> !core_regulator_en; endproperty
  property p_reg_on; !power_mode[1] |=> core_regulator_en; endproperty
  property p_rd_hi; done && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  property p_fsm_pad; done && !pwrite && paddr[17:2] == `RS_IDX_RADIO_FSM_STATE |-> prdata[7:5] == 3'h0; endproperty
  property p_flg_pad; done && !pwrite && paddr[17:2] == `RS_IDX_PACKET_FLAGS |-> prdata[2:0] == 3'h0; endproperty
  property p_ro_err; done && pwrite && paddr[17:2] inside {[16'hdf3a:16'hdf3d]} |-> !pslverr; endproperty
  a_amp_tx: assert property (p_amp_tx) else $error("amp en tx");
  a_amp_idle: assert property (p_amp_idle) else $error("amp en idle");
  a_lna_rx: assert property (p_lna_rx) else $error("lna en rx");
  a_force_out: assert property (p_force_out) else $error("pin not driven");
  a_reg_off: assert property (p_reg_off) else $error("reg on");
  a_reg_on: assert property (p_reg_on) else $error("reg off");
  a_rd_hi: assert property (p_rd_hi) else $error("rd hi set");
  a_fsm_pad: assert property (p_fsm_pad) else $error("fsm pad");
  a_flg_pad: assert property (p_flg_pad) else $error("flag pad");
  a_ro_err: assert property (p_ro_err) else $error("ro err");
endmodule : radio_status_sva

bind radio_status_and_test_out radio_status_sva u_radio_status_sva (.*);

/* File: dv/cpu_apb_model.sv */
// APB master standing in for the processor.
// Assumes the slave answers with pready after a wait.
module cpu_apb_model (
  // Clock
  input  logic        pclk,
  // APB request
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0]  pstrb,
  // APB answer
  input  logic [31:0] prdata,
  input  logic        pready,
  input  logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus; full strobe, each register one byte
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = {3'b000, 64'h0, 4'hf};
  // ======
  // One transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d,
                      output logic [7:0] rd, output logic err);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 14'h0, idx, 2'b00, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : xfer
endmodule : cpu_apb_model

/* File: dv/radio_status_and_test_out_tb_top.sv */
// Self-checking bench for the radio status block.
// Assumes the design and cpu_apb_model.
`include "radio_status_consts.svh"
module radio_status_and_test_out_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, reg_en, err;
  logic        crc_v, crc_m, cs_in, pq_in, cc_in, sync_in, pend_in, afail_in;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb;
  logic [7:0]  ss_in, tune_in, rd;
  logic [4:0]  code_in;
  logic [2:0]  gpio_out, gpio_oe_n, periph_out, periph_oe_n, pin_out, pin_oe_n;
  logic [1:0]  power_mode;
  int          errors, checks, cyc;
  logic [5:0]  sel_tab [8] = '{6'h00, 6'h08, 6'h09, 6'h0e, 6'h0f, 6'h1b, 6'h1c, 6'h2f};
  logic [2:0]  out_tab [8] = '{3'b011, 3'b111, 3'b000, 3'b000, 3'b000, 3'b111, 3'b111, 3'b000};

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  cpu_apb_model u_cpu_apb_model (.*);
  radio_status_and_test_out u_radio_status_and_test_out (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .signal_strength_in(ss_in),
    .radio_fsm_code_in(code_in), .crc_result_valid(crc_v), .crc_result_match(crc_m),
    .carrier_sense_in(cs_in), .preamble_quality_met_in(pq_in), .channel_clear_in(cc_in),
    .sync_word_seen(sync_in), .packet_end(pend_in), .addr_check_fail(afail_in),
    .synth_tune_in(tune_in), .gpio_out, .gpio_oe_n, .periph_out, .periph_oe_n, .pin_out,
    .pin_oe_n, .power_mode, .core_regulator_en(reg_en), .irq);

  // ======
  // Helpers
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [15:0] idx, input logic [8:0] exp);
    u_cpu_apb_model.xfer(1'b0, idx, 8'h00, rd, err);
    check({err, rd}, exp);
  endtask : rd_chk
  task automatic flg(input logic [8:0] exp);
    rd_chk(`RS_IDX_PACKET_FLAGS, exp);
  endtask : flg
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    u_cpu_apb_model.xfer(1'b1, idx, d, rd, err);
  endtask : wr
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask : step
  // One-cycle pulses: crc, addr fail, end, sync
  task automatic ev(input logic [3:0] m);
    {crc_v, afail_in, pend_in, sync_in} <= m;
    @(posedge pclk);
    {crc_v, afail_in, pend_in, sync_in} <= 4'h0;
    step(2);
  endtask : ev
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // Hang guard; the run needs far less
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // ======
  // Main sequence
  initial begin
    {presetn, code_in, ss_in, tune_in, crc_v, afail_in, pend_in, sync_in, crc_m} = {1'b0, 5'h01, 8'h3c, 8'h5a, 5'h01};
    {cs_in, pq_in, cc_in, gpio_out, gpio_oe_n, periph_out, periph_oe_n} = {3'b101, 12'b101_010_011_100};
    {power_mode, errors, checks, cyc} = '0;
    step(5);
    check({6'h0, pin_oe_n}, 9'h007);
    presetn <= 1'b1;
    wr(`RS_IDX_SIGNAL_STRENGTH, 8'hff);
    wr(`RS_IDX_SYNTH_TUNE, 8'h00);
    rd_chk(`RS_IDX_SIGNAL_STRENGTH, 9'h03c);
    rd_chk(`RS_IDX_SYNTH_TUNE, 9'h05a);
    rd_chk(16'hdf50, 9'h100);
    for (int c = 0; c < 23; c++) begin
      code_in <= 5'(c);
      step(1);
      rd_chk(`RS_IDX_RADIO_FSM_STATE, 9'(c));
    end
    // Receive: CRC, sync, each way sync drops
    code_in <= 5'h0d;
    step(2);
    ev(4'h8);
    ev(4'h1);
    flg(9'h0d8);
    cs_in <= 1'b0;
    pq_in <= 1'b1;
    cc_in <= 1'b0;
    ev(4'h2);
    flg(9'h0a0);
    ev(4'h1);
    ev(4'h4);
    flg(9'h0a0);
    ev(4'h1);
    code_in <= 5'h11;
    step(2);
    flg(9'h0a0);
    code_in <= 5'h0d;
    step(2);
    flg(9'h020);
    code_in <= 5'h13;
    ev(4'h1);
    code_in <= 5'h16;
    step(2);
    flg(9'h020);
    // Interrupt: masked, unmasked, write-one clear
    check({8'h0, irq}, 9'h000);
    wr(`RS_IDX_IRQ_MASK, 8'h02);
    step(3);
    check({8'h0, irq}, 9'h001);
    rd_chk(`RS_IDX_IRQ_STATUS, 9'h00f);
    wr(`RS_IDX_IRQ_STATUS, 8'h02);
    step(3);
    check({8'h0, irq}, 9'h000);
    rd_chk(`RS_IDX_IRQ_STATUS, 9'h00d);
    // Every selector code on all pins, peripheral chosen
    code_in <= 5'h01;
    wr(`RS_IDX_PORT1_FUNC_SEL, 8'h07);
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 3; k++) wr(16'(`RS_IDX_TEST_OUT_CONFIG0 + k), {2'b00, sel_tab[i]});
      step(2);
      check({3'h0, pin_oe_n, pin_out}, {3'h0, (i == 0) ? 3'b100 : 3'b000, out_tab[i]});
    end
    for (int k = 0; k < 3; k++) wr(16'(`RS_IDX_TEST_OUT_CONFIG0 + k), 8'h00);
    wr(`RS_IDX_PORT1_FUNC_SEL, 8'h00);
    step(2);
    check({3'h0, pin_oe_n, pin_out}, 9'h015);
    wr(`RS_IDX_TEST_OUT_CONFIG0, 8'h1b);
    code_in <= 5'h13;
    step(4);
    check({7'h0, pin_oe_n[0], pin_out[0]}, 9'h000);
    wr(`RS_IDX_TEST_OUT_CONFIG0, 8'h1c);
    code_in <= 5'h0d;
    step(4);
    check({7'h0, pin_oe_n[0], pin_out[0]}, 9'h000);
    // Power modes: regulator follows, registers kept
    for (int m = 0; m < 4; m++) begin
      power_mode <= 2'(m);
      step(2);
      check({8'h0, reg_en}, 9'(m < 2));
    end
    rd_chk(`RS_IDX_IRQ_MASK, 9'h002);
    wrap_up();
  end
endmodule : radio_status_and_test_out_tb_top
